// ### shared/aop_cfg.svh
`ifndef AOP_CFG_SVH
`define AOP_CFG_SVH
// Register byte offsets
`define AOP_OFF_CTRL 12'h000
`define AOP_OFF_STAT 12'h004
`define AOP_OFF_WORD 12'h008
`define AOP_OFF_CNT 12'h00C
// Control fields and reset values
`define AOP_CTRL_HOLD 0
`define AOP_CTRL_RST 32'h0000_0000
// Status field positions
`define AOP_STAT_MODE 0
`define AOP_STAT_REF 2
`define AOP_STAT_OVR 4
`define AOP_STAT_AMP 5
// Clip codes
`define AOP_MAX_8X 16'h7FFF
`define AOP_MIN_8X 16'h8000
`define AOP_MAX_4X 16'h7EE3
`define AOP_LOB_4X 16'h810C
`define AOP_MIN_4X 16'h811C
`define AOP_MAX_2X 16'h7FBE
`define AOP_MIN_2X 16'h8041
// Decimation factors
`define AOP_DEC_8X 4'h8
`define AOP_DEC_4X 4'h4
`define AOP_DEC_2X 4'h2
`define AOP_DEC_1X 4'h1
`endif

// ### shared/aop_pkg.sv
package aop_pkg;
	typedef enum logic [1:0] {AOP_M8X, AOP_M2X, AOP_M4X, AOP_M1X} aop_mode_t;
	typedef enum logic [1:0] {AOP_REF_INT, AOP_REF_SENSE, AOP_REF_EXT} aop_ref_t;
endpackage

// ### shared/aop_ctl_if.sv
`timescale 1ns/100ps
interface aop_ctl_if;
	import aop_pkg::*;
	aop_mode_t mode;
	aop_ref_t  ref_mode;
	logic      ref_fb_sel;
	logic      ref_amp_en;
	modport src (output mode, ref_mode, ref_fb_sel, ref_amp_en);
	modport snk (input mode, ref_mode, ref_fb_sel, ref_amp_en);
endinterface

// ### rtl/aop_strap_dec.sv
`timescale 1ns/100ps
`include "aop_cfg.svh"
module aop_strap_dec
	import aop_pkg::*;
(
	input  wire logic       pclk,            // Converter clock
	input  wire logic       presetn,         // Async reset, low
	input  wire logic       sense_low_cmp,   // Sense below low threshold
	input  wire logic       sense_supply_cmp,// Sense at analog supply
	input  wire logic [2:0] mode_cmp,        // Mode pin thermometer
	aop_ctl_if.src          ctl              // Decoded straps
);
	localparam int NB = 5;
	logic [NB-1:0] pin_raw;
	logic [NB-1:0] s1, s2, s3, filt;
	assign pin_raw = {mode_cmp, sense_supply_cmp, sense_low_cmp};

	////////////////////////////////////////////////////////////
	// Pins from the analog side: three stages, accept when 2 and 3 agree
	generate
		for (genvar i = 0; i < NB; i++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
				if (!presetn)
				begin
					s1[i]   <= 1'b0;
					s2[i]   <= 1'b0;
					s3[i]   <= 1'b0;
					filt[i] <= 1'b0;
				end
				else
				begin
					s1[i] <= pin_raw[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i])
						filt[i] <= s3[i];
				end
		end
	endgenerate

	////////////////////////////////////////////////////////////
	// Reference decode: supply level wins, then low threshold
	aop_ref_t  next_ref;
	aop_mode_t next_mode;
	assign next_ref = filt[1] ? AOP_REF_EXT : (filt[0] ? AOP_REF_INT : AOP_REF_SENSE);
	// Thermometer mode code; rising pin level walks 8x, 2x, 4x, 1x
	assign next_mode = filt[4] ? AOP_M1X : (filt[3] ? AOP_M4X : (filt[2] ? AOP_M2X : AOP_M8X));

	// Latched once per clock; sampled on the rising edge since one clock serves all
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctl.ref_mode <= AOP_REF_INT;
			ctl.mode     <= AOP_M8X;
		end
		else
		begin
			ctl.ref_mode <= next_ref;
			ctl.mode     <= next_mode;
		end

	assign ctl.ref_fb_sel = (ctl.ref_mode == AOP_REF_SENSE);
	assign ctl.ref_amp_en = (ctl.ref_mode != AOP_REF_EXT);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ref_ext_off: assert property (filt[1] |=> !ctl.ref_amp_en)
		else $error("amp not disabled for external ref");
	a_ref_int_net: assert property (filt[0] && !filt[1] |=> !ctl.ref_fb_sel && ctl.ref_amp_en)
		else $error("internal network not chosen");
	a_ref_sense_fb: assert property (!filt[0] && !filt[1] |=> ctl.ref_fb_sel)
		else $error("sense feedback not chosen");
endmodule

// ### rtl/aop_port.sv
`timescale 1ns/100ps
`include "aop_cfg.svh"
module aop_port
	import aop_pkg::*;
#(
	parameter int RAW_W = 18 // Filter result width
)(
	input  wire logic             pclk,              // Converter clock, 40 MHz
	input  wire logic             presetn,           // Async reset, low
	input  wire logic             psel,              // APB select
	input  wire logic             penable,           // APB enable
	input  wire logic             pwrite,            // APB write
	input  wire logic [11:0]      paddr,             // APB byte address
	input  wire logic [31:0]      pwdata,            // APB write data
	output logic      [31:0]      prdata,            // APB read data
	output logic                  pready,            // APB ready
	output logic                  pslverr,           // APB error
	input  wire logic             sense_low_cmp,     // Sense below low threshold
	input  wire logic             sense_supply_cmp,  // Sense at analog supply
	input  wire logic [2:0]       mode_cmp,          // Mode pin thermometer
	input  wire logic [RAW_W-1:0] filt_result,       // Filter output, signed
	input  wire logic [11:0]      mod_result,        // Modulator output, signed
	input  wire logic             mod_ovr,           // Modulator overrange
	input  wire logic             chip_sel_n,        // Output select, low
	input  wire logic             read_en,           // Output read, high
	output logic      [15:0]      output_word_bits,  // Parallel word
	output logic      [15:0]      output_word_oe,    // Pin drive enables
	output logic                  word_valid_strobe, // Word valid strobe
	output logic                  overrange_flag,    // Overrange indication
	output logic                  ref_fb_sel,        // Feedback from sense pin
	output logic                  ref_buffer_amp_en  // Reference amplifier on
);
	// Clip bounds are 16-bit codes; a narrower result cannot hold them
	if (RAW_W < 16 || RAW_W > 32)
	begin : g_bad_raw_w
		$error("RAW_W must be 16 to 32");
	end

	aop_ctl_if ctl ();

	aop_strap_dec u_strap (
		.pclk             (pclk),
		.presetn          (presetn),
		.sense_low_cmp    (sense_low_cmp),
		.sense_supply_cmp (sense_supply_cmp),
		.mode_cmp         (mode_cmp),
		.ctl              (ctl.src)
	);

	assign ref_fb_sel        = ctl.ref_fb_sel;
	assign ref_buffer_amp_en = ctl.ref_amp_en;

	////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	logic [31:0] ctrl;
	logic [15:0] word_cnt;
	logic        acc_phase, wr_acc, hit_ctrl, hit_stat, hit_word, hit_cnt, hit_any;
	logic [31:0] stat_val;

	assign acc_phase = psel & penable;
	assign wr_acc    = acc_phase & pwrite;
	assign hit_ctrl  = (paddr == `AOP_OFF_CTRL);
	assign hit_stat  = (paddr == `AOP_OFF_STAT);
	assign hit_word  = (paddr == `AOP_OFF_WORD);
	assign hit_cnt   = (paddr == `AOP_OFF_CNT);
	assign hit_any   = hit_ctrl | hit_stat | hit_word | hit_cnt;
	assign pready    = 1'b1;
	assign pslverr   = acc_phase & ~hit_any;
	assign stat_val  = {26'h0, ctl.ref_amp_en, overrange_flag, ctl.ref_mode, ctl.mode};
	assign prdata    = hit_ctrl ? ctrl :
	                   hit_stat ? stat_val :
	                   hit_word ? {16'h0, output_word_bits} :
	                   hit_cnt  ? {16'h0, word_cnt} : 32'h0;

	// Only the hold bit is writable; the rest reads zero
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ctrl <= `AOP_CTRL_RST;
		else if (wr_acc && hit_ctrl)
			ctrl <= {31'h0, pwdata[`AOP_CTRL_HOLD]};

	////////////////////////////////////////////////////////////
	// Decimation divider: one strobe period per word
	aop_mode_t mode_q;
	logic [3:0] dec, half, next_cnt;
	logic [3:0] cnt;
	logic       run, mode_chg, wrap, strobe_q, next_strobe;

	assign dec = (mode_q == AOP_M8X) ? `AOP_DEC_8X :
	             (mode_q == AOP_M4X) ? `AOP_DEC_4X :
	             (mode_q == AOP_M2X) ? `AOP_DEC_2X : `AOP_DEC_1X;
	assign half        = dec >> 1;
	assign mode_chg    = (ctl.mode != mode_q);
	// 4'hF marks a primed divider, so the first edge after reset or a mode change starts a word
	assign wrap        = (cnt == dec - 4'h1) || (cnt == 4'hF);
	assign next_cnt    = mode_chg ? 4'hF : (wrap ? 4'h0 : cnt + 4'h1);
	assign next_strobe = !mode_chg && (next_cnt < half);

	// A mode change restarts the divider so a word never straddles two factors
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			cnt      <= 4'hF;
			run      <= 1'b0;
			strobe_q <= 1'b0;
			mode_q   <= AOP_M8X;
		end
		else
		begin
			run      <= 1'b1;
			mode_q   <= ctl.mode;
			cnt      <= next_cnt;
			strobe_q <= next_strobe;
		end

	// In 1x the word rate equals the clock, so the strobe follows the clock itself
	// gated by run; its rise is the same edge that loads the word, ahead of clk-to-q.
	assign word_valid_strobe = (mode_q == AOP_M1X) ? (run & pclk) : strobe_q;

	////////////////////////////////////////////////////////////
	// Formatting and clipping
	logic signed [RAW_W-1:0] raw_s, hi_b, lo_b, hi_c;
	logic        [15:0]      hi_code, lo_bound, lo_code, clip_word, fmt_word, next_word;
	logic                    over_hi, under_lo, filt_clip, load_word;

	assign hi_code  = (mode_q == AOP_M8X) ? `AOP_MAX_8X :
	                  (mode_q == AOP_M4X) ? `AOP_MAX_4X : `AOP_MAX_2X;
	assign lo_bound = (mode_q == AOP_M8X) ? `AOP_MIN_8X :
	                  (mode_q == AOP_M4X) ? `AOP_LOB_4X : `AOP_MIN_2X;
	assign lo_code  = (mode_q == AOP_M8X) ? `AOP_MIN_8X :
	                  (mode_q == AOP_M4X) ? `AOP_MIN_4X : `AOP_MIN_2X;
	assign raw_s    = filt_result;
	assign hi_b     = RAW_W'(signed'(hi_code));
	assign lo_b     = RAW_W'(signed'(lo_bound));
	assign over_hi  = (raw_s >= hi_b);
	assign under_lo = (raw_s < lo_b);
	assign hi_c     = over_hi ? hi_b : raw_s;
	// 4x clips results below its lower bound to a code above that bound; the bound value itself passes
	assign clip_word = over_hi ? hi_code : (under_lo ? lo_code : hi_c[15:0]);
	assign filt_clip = (mode_q == AOP_M8X) && (raw_s > hi_b || raw_s < lo_b);
	assign fmt_word  = (mode_q == AOP_M1X) ? {{4{mod_result[11]}}, mod_result}
	                                       : clip_word;
	assign load_word = !mode_chg && (next_cnt == 4'h0) && !ctrl[`AOP_CTRL_HOLD];
	assign next_word = load_word ? fmt_word : output_word_bits;

	// Word loads on the edge the strobe rises; host inverts bit 15 for offset binary
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			output_word_bits <= 16'h0000;
			overrange_flag   <= 1'b0;
			word_cnt         <= 16'h0000;
		end
		else
		begin
			output_word_bits <= next_word;
			overrange_flag   <= mod_ovr | filt_clip;
			if (load_word)
				word_cnt <= word_cnt + 16'h0001;
		end

	////////////////////////////////////////////////////////////
	// Output gating: pins pass the same three-stage filter as any pin input
	logic [1:0] g1, g2, g3, gf;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			g1 <= 2'b10;
			g2 <= 2'b10;
			g3 <= 2'b10;
			gf <= 2'b10;
		end
		else
		begin
			g1 <= {chip_sel_n, read_en};
			g2 <= g1;
			g3 <= g2;
			gf <= {(g2[1] == g3[1]) ? g3[1] : gf[1], (g2[0] == g3[0]) ? g3[0] : gf[0]};
		end

	logic drive;
	assign drive          = ~gf[1] & gf[0];
	assign output_word_oe = {16{drive}};

	////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_steady(aop_mode_t m);
		mode_q == m && !mode_chg;
	endsequence
	// A mode change may cut the high phase short; the new factor then takes over
	sequence s_half_high;
		(strobe_q || mode_q != AOP_M8X) [*4] ##1 (!strobe_q || mode_q != AOP_M8X || mode_chg);
	endsequence

	a_no_extreme: assert property ((mode_q == AOP_M2X || mode_q == AOP_M4X) && load_word |=>
		output_word_bits != 16'h7FFF && output_word_bits != 16'h8000)
		else $error("extreme code in 2x or 4x");
	a_sat_8x_hi: assert property (s_steady(AOP_M8X) and (load_word && raw_s >= hi_b) |=>
		output_word_bits == 16'h7FFF)
		else $error("8x positive saturation wrong");
	a_clip_2x_lo: assert property (s_steady(AOP_M2X) and (load_word && raw_s < lo_b) |=>
		output_word_bits == 16'h8041)
		else $error("2x negative clip wrong");
	a_ovr_analog: assert property (mode_q != AOP_M8X |=> overrange_flag == $past(mod_ovr))
		else $error("overrange not modulator only");
	a_1x_justify: assert property (s_steady(AOP_M1X) and load_word |=>
		output_word_bits == {{4{$past(mod_result[11])}}, $past(mod_result)})
		else $error("1x word not justified");
	a_drive_gate: assert property ($rose(output_word_oe[0]) |->
		$past(!chip_sel_n && read_en, 3) && $past(!chip_sel_n && read_en, 4))
		else $error("pins driven while deselected");
	a_update_rise: assert property (mode_q != AOP_M1X && $changed(output_word_bits) |-> $rose(strobe_q))
		else $error("word changed off strobe rise");
	a_duty_8x: assert property (s_steady(AOP_M8X) ##0 $rose(strobe_q) |-> s_half_high)
		else $error("8x strobe duty wrong");
	a_period_8x: assert property ($rose(strobe_q) ##0 s_steady(AOP_M8X) ##0 (!ctl.mode[0] && !ctl.mode[1])
		|-> ##8 ($rose(strobe_q) || mode_q != AOP_M8X || $past(mode_chg)))
		else $error("8x strobe period wrong");
	a_reset_low: assert property (@(posedge pclk) disable iff (1'b0) !presetn |-> !strobe_q)
		else $error("strobe high in reset");
endmodule

// ### verification/aop_host_model.sv
`timescale 1ns/100ps
module aop_host_model (
	input  wire logic        strobe,   // Word valid strobe
	input  wire logic [15:0] bits,     // Device data pins
	input  wire logic [15:0] oe,       // Device drive enables
	output logic      [15:0] cap,      // Latched word
	output logic      [15:0] straight, // Offset binary view
	output int               per_t,    // Strobe period, 0.1 ns
	output int               high_t    // Strobe high time, 0.1 ns
);
	logic [15:0] last = 16'h0000;
	realtime     t_rise = 0.0;
	////////////////////////////////////////////////////////////////
	// Released pins read back inverted, so stale data never matches
	always @(bits or oe)
		last = (oe & bits) | (~oe & last);
	// Falling edge lands well after the data has settled
	always @(negedge strobe)
	begin
		cap = (oe & bits) | (~oe & ~last);
		high_t = int'(($realtime - t_rise) * 10);
	end
	// Strobe timing kept in tenths of a ns to hold the 1x half cycle
	always @(posedge strobe)
	begin
		per_t = int'(($realtime - t_rise) * 10);
		t_rise = $realtime;
	end
	assign straight = cap ^ 16'h8000;
endmodule

// ### verification/tb_top.sv
`timescale 1ns/100ps
`include "aop_cfg.svh"
module tb_top;
	import aop_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        sense_low_cmp, sense_supply_cmp, mod_ovr, chip_sel_n, read_en;
	logic        strobe, ovr, fb_sel, amp_en;
	logic [11:0] paddr, mod_result;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  mode_cmp;
	logic [17:0] filt_result;
	logic [15:0] word, oe, cap, h, sb;
	int          per_t, high_t, err_total, check_count, cyc, seed, v;
	logic [2:0]  thm [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
	int          dec [4] = '{8, 2, 4, 1};
	int          vals [5] = '{40000, -40000, -32500, 32702, -32768};
	////////////////////////////////////////////////////////////////
	aop_port #(.RAW_W(18)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sense_low_cmp(sense_low_cmp), .sense_supply_cmp(sense_supply_cmp),
		.mode_cmp(mode_cmp), .filt_result(filt_result), .mod_result(mod_result), .mod_ovr(mod_ovr),
		.chip_sel_n(chip_sel_n), .read_en(read_en), .output_word_bits(word), .output_word_oe(oe),
		.word_valid_strobe(strobe), .overrange_flag(ovr), .ref_fb_sel(fb_sel),
		.ref_buffer_amp_en(amp_en));
	aop_host_model host (.strobe(strobe), .bits(word), .oe(oe), .cap(cap), .straight(sb),
		.per_t(per_t), .high_t(high_t));
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// APB cycle: request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Reference word per mode, clipping done on plain integers
	function automatic logic [15:0] exp_word(input int m, input int x, input logic [11:0] mr);
		int hi, lo;
		hi = 32767;
		lo = -32768;
		if (m == 1)
		begin
			hi = $signed(`AOP_MAX_2X);
			lo = $signed(`AOP_MIN_2X);
		end
		if (m == 2)
		begin
			hi = $signed(`AOP_MAX_4X);
			lo = $signed(`AOP_LOB_4X);
		end
		if (m == 3)
			return {{4{mr[11]}}, mr};
		if (x > hi)
			return hi[15:0];
		if (x < lo)
			return (m == 2) ? `AOP_MIN_4X : lo[15:0];
		return x[15:0];
	endfunction
	////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Hang guard, well above the expected run length
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end
	initial
	begin
		seed = 69565;
		{presetn, psel, penable, pwrite, sense_supply_cmp, mod_ovr, chip_sel_n} = 7'h40;
		{sense_low_cmp, read_en, paddr, pwdata, mode_cmp, filt_result, mod_result} = 'h0;
		sense_low_cmp = 1'b1;
		read_en = 1'b1;
		// A real falling reset edge ahead of the first clock edge, so no flop starts unknown
		#1;
		presetn = 1'b0;
		wait_cyc(5);
		cmp_bit(strobe, 1'b0);
		cmp_val(word, 32'h0);
		wait_cyc(5);
		presetn <= 1'b1;
		wait_cyc(8);
		apb(1'b0, `AOP_OFF_CTRL, 32'h0);
		cmp_val(rd, `AOP_CTRL_RST);
		cmp_bit(er, 1'b0);
		apb(1'b0, 12'h010, 32'h0);
		cmp_bit(er, 1'b1);
		cmp_val(rd, 32'h0);
		// Reference straps {supply, low}; supply wins over low
		for (int i = 0; i < 4; i++)
		begin
			sense_low_cmp <= i[0];
			sense_supply_cmp <= i[1];
			wait_cyc(8);
			cmp_bit(amp_en, !i[1]);
			if (!i[1])
				cmp_bit(fb_sel, !i[0]);
			apb(1'b0, `AOP_OFF_STAT, 32'h0);
			cmp_val(rd[3:2], i[1] ? 2 : (i[0] ? 0 : 1));
		end
		sense_low_cmp <= 1'b1;
		sense_supply_cmp <= 1'b0;
		apb(1'b1, `AOP_OFF_STAT, 32'hFFFF_FFFF);
		// Every mode, with boundary and random results
		for (int m = 0; m < 4; m++)
		begin
			mode_cmp <= thm[m];
			wait_cyc(10);
			apb(1'b0, `AOP_OFF_STAT, 32'h0);
			cmp_val(rd[1:0], m);
			for (int k = 0; k < 7; k++)
			begin
				v = (k < 5) ? vals[k] : $random(seed) % 40000;
				filt_result <= v[17:0];
				mod_result <= 12'($random(seed));
				mod_ovr <= 1'($random(seed));
				wait_cyc(30);
				cmp_val(cap, exp_word(m, v, mod_result));
				cmp_val(sb, exp_word(m, v, mod_result) ^ 16'h8000);
				cmp_bit(ovr, mod_ovr | (m == 0 && (v > 32767 || v < -32768)));
				cmp_val(per_t, 250 * dec[m]);
				cmp_val(high_t * 2, 250 * dec[m]);
				apb(1'b0, `AOP_OFF_WORD, 32'h0);
				cmp_val(rd[15:0], exp_word(m, v, mod_result));
			end
		end
		// Drive enables for all four select and read levels
		for (int i = 0; i < 4; i++)
		begin
			chip_sel_n <= i[0];
			read_en <= i[1];
			wait_cyc(6);
			cmp_val(oe, (i == 2) ? 16'hFFFF : 16'h0);
		end
		chip_sel_n <= 1'b0;
		read_en <= 1'b1;
		mode_cmp <= thm[0];
		wait_cyc(30);
		// Hold freezes the word while the strobe keeps running
		apb(1'b1, `AOP_OFF_CTRL, 32'h1);
		apb(1'b0, `AOP_OFF_CTRL, 32'h0);
		cmp_val(rd, 32'h1);
		h = cap;
		cmp_val(h, exp_word(0, v, 12'h0));
		filt_result <= 18'h01234;
		wait_cyc(30);
		cmp_val(cap, h);
		cmp_val(per_t, 2000);
		apb(1'b1, `AOP_OFF_CTRL, 32'h0);
		wait_cyc(30);
		cmp_val(cap, exp_word(0, 32'h1234, 12'h0));
		// Second reset in mid-run
		presetn <= 1'b0;
		wait_cyc(3);
		cmp_bit(strobe, 1'b0);
		cmp_val(word, 32'h0);
		presetn <= 1'b1;
		wait_cyc(4);
		// Divider restarts at the first edge after release and loads a fresh word
		cmp_val(word, 32'h1234);
		cmp_bit(strobe, 1'b1);
		summarize();
	end
endmodule
